// File: hw/jdap_pkg.sv
// Shared constants and types of the JTAG debug access port
package jdap_pkg;

	// ****************************************************************
	// TAP controller states, one-hot
	// ****************************************************************
	typedef enum logic [15:0] {
		TS_RESET     = 16'h0001,
		TS_IDLE      = 16'h0002,
		TS_SEL_DR    = 16'h0004,
		TS_CAP_DR    = 16'h0008,
		TS_SHIFT_DR  = 16'h0010,
		TS_EXIT1_DR  = 16'h0020,
		TS_PAUSE_DR  = 16'h0040,
		TS_EXIT2_DR  = 16'h0080,
		TS_UPD_DR    = 16'h0100,
		TS_SEL_IR    = 16'h0200,
		TS_CAP_IR    = 16'h0400,
		TS_SHIFT_IR  = 16'h0800,
		TS_EXIT1_IR  = 16'h1000,
		TS_PAUSE_IR  = 16'h2000,
		TS_EXIT2_IR  = 16'h4000,
		TS_UPD_IR    = 16'h8000
	} jdap_state_e;

	// ****************************************************************
	// Register widths and instruction codes
	// ****************************************************************
	localparam int          IR_W        = 4;
	localparam int          DR_W        = 32;
	localparam int          EMU_W       = 8;
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;
	localparam logic [3:0]  INS_IDCODE  = 4'h2;
	localparam logic [3:0]  INS_EMU     = 4'h6;
	localparam logic [3:0]  INS_DBG_REQ = 4'h7;
	localparam logic [3:0]  INS_BYPASS  = 4'hF;

	// ****************************************************************
	// Pin synchroniser lanes and debug event timing
	// ****************************************************************
	localparam int          SYNC_N      = 4;
	localparam int          LN_TCK      = 0;
	localparam int          LN_TMS      = 1;
	localparam int          LN_TDI      = 2;
	localparam int          LN_DEV      = 3;
	localparam int          DE_PULSE_N  = 3;
	localparam int          DE_GUARD_N  = 4;
	localparam int          CNT_W       = 3;
	localparam logic [2:0]  DE_PULSE_C  = 3'(DE_PULSE_N);
	localparam logic [2:0]  DE_GUARD_C  = 3'(DE_GUARD_N);
	localparam logic [2:0]  CNT_ZERO    = 3'h0;
	localparam logic [2:0]  CNT_ONE     = 3'h1;

endpackage

// File: hw/jdap_tap_if.sv
// Carrier between the access port top and its TAP state machine
`timescale 1ns/1ps
interface jdap_tap_if;
	import jdap_pkg::*;

	logic        tck_rise;
	logic        tms;
	jdap_state_e state;

	modport fsm (input tck_rise, input tms, output state);
	modport user (output tck_rise, output tms, input state);
endinterface

// File: hw/jdap_tap_fsm.sv
// Sixteen-state TAP controller stepped by sampled test clock rising edges
`timescale 1ns/1ps
module jdap_tap_fsm (
	// Clock and resets
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	input  wire logic   trst_n_i,
	// Link to the top
	jdap_tap_if.fsm     tap
);
	import jdap_pkg::*;

	jdap_state_e state_r;
	jdap_state_e state_nxt;

	assign tap.state = state_r;

	always_comb begin
		unique case (state_r)
			TS_RESET:    state_nxt = tap.tms ? TS_RESET   : TS_IDLE;
			TS_IDLE:     state_nxt = tap.tms ? TS_SEL_DR  : TS_IDLE;
			TS_SEL_DR:   state_nxt = tap.tms ? TS_SEL_IR  : TS_CAP_DR;
			TS_CAP_DR:   state_nxt = tap.tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_SHIFT_DR: state_nxt = tap.tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_EXIT1_DR: state_nxt = tap.tms ? TS_UPD_DR  : TS_PAUSE_DR;
			TS_PAUSE_DR: state_nxt = tap.tms ? TS_EXIT2_DR : TS_PAUSE_DR;
			TS_EXIT2_DR: state_nxt = tap.tms ? TS_UPD_DR  : TS_SHIFT_DR;
			TS_UPD_DR:   state_nxt = tap.tms ? TS_SEL_DR  : TS_IDLE;
			TS_SEL_IR:   state_nxt = tap.tms ? TS_RESET   : TS_CAP_IR;
			TS_CAP_IR:   state_nxt = tap.tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_SHIFT_IR: state_nxt = tap.tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_EXIT1_IR: state_nxt = tap.tms ? TS_UPD_IR  : TS_PAUSE_IR;
			TS_PAUSE_IR: state_nxt = tap.tms ? TS_EXIT2_IR : TS_PAUSE_IR;
			TS_EXIT2_IR: state_nxt = tap.tms ? TS_UPD_IR  : TS_SHIFT_IR;
			TS_UPD_IR:   state_nxt = tap.tms ? TS_SEL_DR  : TS_IDLE;
		endcase
	end

	// Test reset acts at on_chip_emulation_module, with no clock edge needed
	always_ff @(posedge clk_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			state_r <= TS_RESET; // see [R5] see [R11]
		end else if (!rst_n_i) begin
			state_r <= TS_RESET;
		end else if (tap.tck_rise) begin
			state_r <= state_nxt; // see [R4] see [R11]
		end
	end

endmodule

// File: hw/jdap_top.sv
// JTAG debug access port with debug event pin handling
//
// Behaviour
// [R1] Test data input is captured on every rising test clock edge; the code shifts it in only in Shift-IR and Shift-DR.
// [R2] Test data output is driven only in Shift-IR and Shift-DR, else released.
// [R3] Test data output changes only on falling test clock edges.
// [R4] The TAP state advances by the mode select level at rising test clock edges.
// [R5] Test reset returns the TAP to Test-Logic-Reset at on_chip_emulation_module, without a test clock.
// [R6] The external controller asserts test reset after power-up.
// [R7] Debug event pin asserted from outside: finish instruction, save pipeline, enter debug.
// [R8] In debug mode the core halts and awaits commands from the serial path.
// [R9] On entering debug mode the debug event pin is driven for exactly three clocks.
// [R10] Only the debug event pin bypasses the JTAG port into the emulation module.
// [R11] The TAP is the standard sixteen-state machine, reset into Test-Logic-Reset.
`timescale 1ns/1ps
module jdap_top #(
	parameter logic [31:0] IDCODE_VALUE = 32'h0A5A_0001 // Arbitrary identity value
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	// JTAG pins
	input  wire logic                     tck_i,
	input  wire logic                     tms_i,
	input  wire logic                     tdi_i,
	input  wire logic                     trst_n_i,
	output logic                          tdo_o,
	output logic                          tdo_oe_o,
	// Debug event pin, active low, open drain
	input  wire logic                     debug_event_pin_n_i,
	output logic                          debug_event_pin_n_o,
	output logic                          debug_event_pin_n_oe_o,
	// Core side
	input  wire logic                     core_in_debug_i,
	input  wire logic [jdap_pkg::EMU_W-1:0] emu_status_i,
	output logic                          core_debug_req_o,
	output logic                          emu_cmd_valid_o,
	output logic [jdap_pkg::EMU_W-1:0]    emu_cmd_data_o
);
	import jdap_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [SYNC_N-1:0] pins;
	logic [SYNC_N-1:0] sync1_r;
	logic [SYNC_N-1:0] sync2_r;
	logic              tck_q_r;
	logic              dev_q_r;

	assign pins = {debug_event_pin_n_i, tdi_i, tms_i, tck_i};

	genvar g;
	generate
		for (g = 0; g < SYNC_N; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				// Each lane resets to its pin's idle level, so no false edge follows reset
				if (!rst_n_i) begin
					sync1_r[g] <= (g != LN_TCK);
					sync2_r[g] <= (g != LN_TCK);
				end else begin
					sync1_r[g] <= pins[g];
					sync2_r[g] <= sync1_r[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tck_q_r <= 1'b0;
			dev_q_r <= 1'b1;
		end else begin
			tck_q_r <= sync2_r[LN_TCK];
			dev_q_r <= sync2_r[LN_DEV];
		end
	end

	logic tck_rise;
	logic tck_fall;
	logic tdi_s;

	assign tck_rise = sync2_r[LN_TCK] & ~tck_q_r;
	assign tck_fall = ~sync2_r[LN_TCK] & tck_q_r;
	assign tdi_s    = sync2_r[LN_TDI];

	// ****************************************************************
	// TAP state machine
	// ****************************************************************
	jdap_tap_if tap ();

	assign tap.tck_rise = tck_rise;
	assign tap.tms      = sync2_r[LN_TMS]; // see [R4]

	jdap_tap_fsm u_fsm (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.trst_n_i (trst_n_i),
		.tap      (tap)
	);

	logic in_reset;
	logic cap_ir;
	logic shift_ir;
	logic upd_ir;
	logic cap_dr;
	logic shift_dr;
	logic upd_dr;

	assign in_reset = (tap.state == TS_RESET);
	assign cap_ir   = (tap.state == TS_CAP_IR);
	assign shift_ir = (tap.state == TS_SHIFT_IR);
	assign upd_ir   = (tap.state == TS_UPD_IR);
	assign cap_dr   = (tap.state == TS_CAP_DR);
	assign shift_dr = (tap.state == TS_SHIFT_DR);
	assign upd_dr   = (tap.state == TS_UPD_DR);

	// ****************************************************************
	// Instruction register
	// ****************************************************************
	logic [IR_W-1:0] ir_shift_r;
	logic [IR_W-1:0] ir_r;
	logic            dbg_ins_p_r;

	always_ff @(posedge clk_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			ir_shift_r <= IR_CAPTURE;
		end else if (!rst_n_i) begin
			ir_shift_r <= IR_CAPTURE;
		end else if (tck_rise && cap_ir) begin
			ir_shift_r <= IR_CAPTURE;
		end else if (tck_rise && shift_ir) begin
			ir_shift_r <= {tdi_s, ir_shift_r[IR_W-1:1]}; // see [R1]
		end
	end

	// Update acts on the falling edge, as a TAP normally does
	always_ff @(posedge clk_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			ir_r <= INS_IDCODE;
		end else if (!rst_n_i || in_reset) begin
			ir_r <= INS_IDCODE;
		end else if (tck_fall && upd_ir) begin
			ir_r <= ir_shift_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dbg_ins_p_r <= 1'b0;
		end else begin
			dbg_ins_p_r <= tck_fall && upd_ir && (ir_shift_r == INS_DBG_REQ);
		end
	end

	// ****************************************************************
	// Data registers
	// ****************************************************************
	logic [DR_W-1:0] dr_r;

	always_ff @(posedge clk_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			dr_r <= '0;
		end else if (!rst_n_i) begin
			dr_r <= '0;
		end else if (tck_rise && cap_dr) begin
			unique case (ir_r)
				INS_IDCODE: dr_r <= IDCODE_VALUE;
				INS_EMU:    dr_r <= {{(DR_W-EMU_W){1'b0}}, emu_status_i};
				default:    dr_r <= '0;
			endcase
		end else if (tck_rise && shift_dr) begin
			unique case (ir_r) // see [R1]
				INS_IDCODE: dr_r <= {tdi_s, dr_r[DR_W-1:1]};
				INS_EMU:    dr_r <= {{(DR_W-EMU_W){1'b0}}, tdi_s, dr_r[EMU_W-1:1]};
				default:    dr_r <= {{(DR_W-1){1'b0}}, tdi_s};
			endcase
		end
	end

	// Commands reach the emulation logic only through the JTAG data path
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			emu_cmd_valid_o <= 1'b0;
			emu_cmd_data_o  <= '0;
		end else begin
			emu_cmd_valid_o <= tck_fall && upd_dr && (ir_r == INS_EMU) && core_in_debug_i; // see [R8] see [R10]
			if (tck_fall && upd_dr && (ir_r == INS_EMU)) begin
				emu_cmd_data_o <= dr_r[EMU_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Test data output
	// ****************************************************************
	always_ff @(posedge clk_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (!rst_n_i) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall) begin
			tdo_o    <= shift_ir ? ir_shift_r[0] : dr_r[0]; // see [R3]
			tdo_oe_o <= shift_ir | shift_dr;                // see [R2]
		end
	end

	// ****************************************************************
	// Debug event pin
	// ****************************************************************
	logic [CNT_W-1:0] de_cnt_r;
	logic [CNT_W-1:0] guard_cnt_r;
	logic             in_dbg_q_r;
	logic             dbg_req_r;
	logic             de_request;

	// Our own pulse echoes back through the synchroniser, so it is masked
	assign de_request = dev_q_r & ~sync2_r[LN_DEV] & (de_cnt_r == CNT_ZERO) & (guard_cnt_r == CNT_ZERO);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			in_dbg_q_r <= 1'b0;
			de_cnt_r   <= CNT_ZERO;
		end else begin
			in_dbg_q_r <= core_in_debug_i;
			if (core_in_debug_i && !in_dbg_q_r) begin
				de_cnt_r <= DE_PULSE_C; // see [R9]
			end else if (de_cnt_r != CNT_ZERO) begin
				de_cnt_r <= de_cnt_r - CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			guard_cnt_r <= CNT_ZERO;
		end else if (de_cnt_r == CNT_ONE) begin
			guard_cnt_r <= DE_GUARD_C;
		end else if (guard_cnt_r != CNT_ZERO) begin
			guard_cnt_r <= guard_cnt_r - CNT_ONE;
		end
	end

	// Request held until the core has finished its instruction and saved the pipeline
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dbg_req_r <= 1'b0;
		end else if ((de_request || dbg_ins_p_r) && !core_in_debug_i) begin
			dbg_req_r <= 1'b1; // see [R7] see [R10]
		end else if (core_in_debug_i) begin
			dbg_req_r <= 1'b0; // see [R8]
		end
	end

	assign core_debug_req_o       = dbg_req_r;
	assign debug_event_pin_n_o    = 1'b0;
	assign debug_event_pin_n_oe_o = (de_cnt_r != CNT_ZERO); // see [R9]

endmodule

// File: test/jdap_monitor.sv
// Checker of the debug access port pins
`timescale 1ns/1ps
module jdap_monitor (
	// Clock and resets
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic trst_n_i,
	// JTAG and debug event pins
	input wire logic tck_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire logic debug_event_pin_n_i,
	input wire logic debug_event_pin_n_o,
	input wire logic debug_event_pin_n_oe_o,
	// Core side
	input wire logic core_in_debug_i,
	input wire logic core_debug_req_o,
	input wire logic emu_cmd_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	pulse_len_a:
	assert property ($rose(debug_event_pin_n_oe_o) |-> debug_event_pin_n_oe_o[*3] ##1 !debug_event_pin_n_oe_o)
		else $error("pin drive length");
	pulse_cause_a:
	assert property ($rose(core_in_debug_i) |=> debug_event_pin_n_oe_o) else $error("no pin drive");
	drive_low_a:
	assert property (debug_event_pin_n_oe_o |-> !debug_event_pin_n_o) else $error("pin not low");
	trst_clear_a:
	assert property (!trst_n_i |-> !tdo_oe_o) else $error("tdo on in test reset");
	tdo_fall_a:
	assert property ($changed(tdo_o) && trst_n_i && $past(trst_n_i) |-> !$past(tck_i, 2))
		else $error("tdo moved off falling edge");
	oe_fall_edge_a:
	assert property ($rose(tdo_oe_o) |-> !$past(tck_i, 2) && trst_n_i) else $error("tdo enable timing");
	ext_req_a:
	assert property ($fell(debug_event_pin_n_i) && !debug_event_pin_n_oe_o && !core_in_debug_i
		|-> ##[2:6] core_debug_req_o) else $error("no debug request");
	req_hold_a:
	assert property (core_debug_req_o && !core_in_debug_i |=> core_debug_req_o) else $error("request dropped");
	cmd_valid_a:
	assert property (emu_cmd_valid_o |-> $past(core_in_debug_i) ##1 !emu_cmd_valid_o) else $error("bad command");

	cover property ($fell(debug_event_pin_n_oe_o));
	cover property (emu_cmd_valid_o);
	cover property ($rose(core_debug_req_o));
endmodule

bind jdap_top jdap_monitor u_jdap_monitor (.clk_i, .rst_n_i, .trst_n_i, .tck_i, .tdo_o, .tdo_oe_o,
	.debug_event_pin_n_i, .debug_event_pin_n_o, .debug_event_pin_n_oe_o, .core_in_debug_i,
	.core_debug_req_o, .emu_cmd_valid_o);

// File: test/jdap_ctl_model.sv
// Behavioural JTAG and debug command controller
`timescale 1ns/1ps
module jdap_ctl_model (
	// Clock
	input  wire logic clk_i,
	// From the port
	input  wire logic tdo_i,
	input  wire logic tdo_oe_i,
	// To the port
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	output logic      trst_n_o,
	output logic      de_pull_o
);
	logic [32:0] res;
	logic        so;
	logic        soe;
	event        done_ev;

	// Test clock stands low between frames; mode and data rest at their pull-up level
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b0;
		de_pull_o = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// One test clock period; TDO is taken just before the rise, long settled since the last fall
	task automatic tbit(input logic m, input logic d);
		tms_o = m;
		tdi_o = d;
		wt(8);
		so = tdo_i;
		soe = tdo_oe_i;
		tck_o = 1'b1;
		wt(16);
		tck_o = 1'b0;
		wt(8);
	endtask

	task automatic scan(input logic ir, input logic [31:0] din, input int n);
		logic [31:0] dout;
		logic        ok;
		dout = '0;
		ok = 1'b1;
		tbit(1'b1, 1'b1);
		if (ir) tbit(1'b1, 1'b1);
		tbit(1'b0, 1'b1);
		tbit(1'b0, 1'b1);
		for (int i = 0; i < n; i++) begin
			tbit(i == n - 1, din[i]);
			dout[i] = so;
			ok &= soe;
		end
		tbit(1'b1, 1'b1);
		ok &= !soe;
		tbit(1'b0, 1'b1);
		res = {ok, dout};
		->done_ev;
	endtask

	task automatic trst_pulse();
		trst_n_o = 1'b0;
		#1;
		res = {tdo_oe_i, 32'h0000_0000};
		->done_ev;
		wt(2);
		trst_n_o = 1'b1;
		wt(3);
	endtask

	task automatic de_req(input int n);
		de_pull_o = 1'b1;
		wt(n);
		de_pull_o = 1'b0;
	endtask
endmodule

// File: test/jdap_top_tb.sv
// Self-checking bench of the JTAG debug access port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module jdap_top_tb;
	import jdap_pkg::*;
	localparam logic [31:0] ID_VAL = 32'h1234_5678; // Arbitrary identity value
	logic             clk = 1'b0;
	logic             rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, de_o, de_oe, de_pull, core_dbg, req, cmd_v;
	logic             req_d = 1'b0;
	logic [EMU_W-1:0] status, cmd_d;
	logic [32:0]      exp_q[$], e;
	logic [31:0]      d;
	int               n_fail = 0, n_checks = 0, seed = 6, cnt = 0;
	wire              de_w = ~((de_oe & ~de_o) | de_pull); // Open drain with pull-up

	initial forever #2.5 clk = ~clk;

	jdap_top #(.IDCODE_VALUE(ID_VAL)) u_jdap_top (.clk_i(clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .debug_event_pin_n_i(de_w),
		.debug_event_pin_n_o(de_o), .debug_event_pin_n_oe_o(de_oe), .core_in_debug_i(core_dbg),
		.emu_status_i(status), .core_debug_req_o(req), .emu_cmd_valid_o(cmd_v), .emu_cmd_data_o(cmd_d));
	jdap_ctl_model u_jdap_ctl_model (.clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
		.tdi_o(tdi), .trst_n_o(trst_n), .de_pull_o(de_pull));

	function automatic logic [32:0] nxt();
		return exp_q.size() ? exp_q.pop_front() : 'x;
	endfunction

	always @(u_jdap_ctl_model.done_ev) begin
		e = nxt();
		`CHK("scan", e, u_jdap_ctl_model.res)
	end

	always @(posedge clk) begin
		if (de_oe === 1'b1) cnt++;
		else if (cnt != 0) begin
			e = nxt();
			`CHK("pulse", e, 33'(cnt))
			cnt = 0;
		end
		if (cmd_v === 1'b1) begin
			e = nxt();
			`CHK("cmd", e, {25'h0, cmd_d})
		end
		if (req === 1'b1 && req_d !== 1'b1) begin
			e = nxt();
			`CHK("req", e, 33'h1)
		end
		req_d = req;
	end

	task automatic sc(input logic ir, input logic [31:0] din, input int n, input logic [31:0] ev);
		exp_q.push_back({1'b1, ev});
		u_jdap_ctl_model.scan(ir, din, n);
	endtask

	task automatic trs();
		exp_q.push_back(33'h0);
		u_jdap_ctl_model.trst_pulse();
	endtask

	// Core enters or leaves debug mode; a three-clock pin pulse is expected on entry only
	task automatic dbg(input logic on);
		if (on) exp_q.push_back(33'd3);
		core_dbg = on;
		repeat (12) @(posedge clk);
		#1;
	endtask

	task automatic end_sim();
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#400_000;
		n_fail++;
		end_sim();
	end

	initial begin
		rst_n = 1'b0;
		core_dbg = 1'b0;
		status = EMU_W'($random(seed));
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		trs();
		u_jdap_ctl_model.tbit(1'b0, 1'b1);
		sc(1'b0, $random(seed), 32, ID_VAL);
		sc(1'b1, 32'(INS_EMU), 4, 32'(IR_CAPTURE));
		sc(1'b0, $random(seed), 8, 32'(status));
		dbg(1'b1);
		d = $random(seed);
		exp_q.push_back({25'h0, d[7:0]});
		sc(1'b0, d, 8, 32'(status));
		dbg(1'b0);
		exp_q.push_back(33'h1);
		u_jdap_ctl_model.de_req(4);
		u_jdap_ctl_model.wt(20);
		dbg(1'b1);
		dbg(1'b0);
		exp_q.push_back(33'h1);
		sc(1'b1, 32'(INS_DBG_REQ), 4, 32'(IR_CAPTURE));
		dbg(1'b1);
		dbg(1'b0);
		u_jdap_ctl_model.tbit(1'b1, 1'b1);
		repeat (3) u_jdap_ctl_model.tbit(1'b0, 1'b1);
		trs();
		u_jdap_ctl_model.tbit(1'b0, 1'b1);
		sc(1'b0, $random(seed), 32, ID_VAL);
		sc(1'b1, 32'(INS_EMU), 4, 32'(IR_CAPTURE));
		repeat (5) u_jdap_ctl_model.tbit(1'b1, 1'b1);
		u_jdap_ctl_model.tbit(1'b0, 1'b1);
		sc(1'b0, $random(seed), 32, ID_VAL);
		// Mid-run system reset with test reset high: the TAP must fall back to the identity instruction
		sc(1'b1, 32'(INS_EMU), 4, 32'(IR_CAPTURE));
		rst_n = 1'b0;
		u_jdap_ctl_model.wt(4);
		rst_n = 1'b1;
		u_jdap_ctl_model.wt(3);
		u_jdap_ctl_model.tbit(1'b0, 1'b1);
		sc(1'b0, $random(seed), 32, ID_VAL);
		repeat (20) @(posedge clk);
		`CHK("left", 33'h0, 33'(exp_q.size()))
		end_sim();
	end
endmodule
